// ===== logic/bgrf_pkg.sv
/*
  Shared constants and types for the banked general register file.
  Assumes the core drives one stack operation at a time.
*/
`default_nettype none

package bgrf_pkg;
  // ==========================================================
  // sizes
  localparam int NIB_W = 4;
  localparam int PAIR_W = 8;
  localparam int REG_CNT = 32;
  localparam int REG_AW = 5;
  localparam int BANK_W = 2;
  localparam int RIDX_W = 3;
  localparam int PSEL_W = 3;
  localparam int MEM_AW = 8;
  localparam int SP_W = 8;
  localparam int SBS_W = 2;
  localparam int RET_W = 12;
  localparam int STK_AW = SBS_W + SP_W;
  // ==========================================================
  // map and reset values
  localparam logic [MEM_AW-1:0] REG_AREA_TOP = 8'h1f;
  localparam logic [NIB_W-1:0] FIELD_RESET = 4'h0;
  localparam logic RBE_RESET = 1'b0;
  localparam logic [SP_W-1:0] SP_RESET = 8'h00;
  localparam logic [SBS_W-1:0] SBS_RESET = 2'h0;
  localparam logic [SP_W-1:0] SP_STEP = 8'h02;
  localparam int FLAG_BIT = 7;
  localparam logic [BANK_W-1:0] ALT_FLIP = 2'h1;
  // ==========================================================
  // pair codes: value is the pair's offset within a bank / 2
  typedef enum logic [1:0] {
    BGRF_PAIR_ACC = 2'b00,
    BGRF_PAIR_PTR = 2'b01,
    BGRF_PAIR_AUX = 2'b10,
    BGRF_PAIR_GP = 2'b11
  } bgrf_pair_t;
  typedef enum logic [3:0] {
    BGRF_OP_NOP = 4'b0000,
    BGRF_OP_PUSH_PAIR = 4'b0001,
    BGRF_OP_POP_PAIR = 4'b0010,
    BGRF_OP_PUSH_BANKS = 4'b0011,
    BGRF_OP_POP_BANKS = 4'b0100,
    BGRF_OP_CALL = 4'b0101,
    BGRF_OP_RET = 4'b0110,
    BGRF_OP_INT_ENTER = 4'b0111,
    BGRF_OP_INT_RET = 4'b1000
  } bgrf_op_t;
  typedef enum logic [1:0] {
    BGRF_ST_IDLE = 2'b00,
    BGRF_ST_RD_WAIT = 2'b01,
    BGRF_ST_RD_DATA = 2'b10,
    BGRF_ST_CALL_HI = 2'b11
  } bgrf_state_t;
endpackage : bgrf_pkg

`default_nettype wire

// ===== logic/bgrf_stack_addr.sv
/*
  Stack pointer and stack bank choice registers.
  Assumes inc and dec pulses never coincide.
*/
`default_nettype none

module bgrf_stack_addr (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // software loads
  input wire logic sp_wr_i,
  input wire logic [bgrf_pkg::SP_W-1:0] sp_wdata_i,
  input wire logic sbs_wr_i,
  input wire logic [bgrf_pkg::SBS_W-1:0] sbs_wdata_i,
  // sequencer steps
  input wire logic dec_i,
  input wire logic inc_i,
  // state
  output logic [bgrf_pkg::SP_W-1:0] sp_o,
  output logic [bgrf_pkg::SBS_W-1:0] sbs_o
);
  import bgrf_pkg::*;

  logic [SP_W-1:0] next_sp;
  logic [SBS_W-1:0] next_sbs;

  // ==========================================================
  // pointer update
  always_comb begin
    next_sp = sp_o;
    next_sbs = sbs_o;
    if (dec_i) begin
      next_sp = sp_o - SP_STEP;
    end else if (inc_i) begin
      next_sp = sp_o + SP_STEP;
    end else if (sp_wr_i) begin
      next_sp = sp_wdata_i;
    end
    if (sbs_wr_i) begin
      next_sbs = sbs_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp_o <= SP_RESET;
      sbs_o <= SBS_RESET;
    end else begin
      sp_o <= next_sp;
      sbs_o <= next_sbs;
    end
  end
endmodule : bgrf_stack_addr

`default_nettype wire

// ===== logic/bgrf_core.sv
/*
  Banked general register file with stack sequencing.
  Assumes the core holds op_i for one cycle while busy_o is low and
  that stack memory returns data the cycle after stk_re_o.
*/
`default_nettype none

// Operation
// - stack accesses go to stack pointer within stack bank choice
// - push, pop, call, return and interrupt all use the stack
// - four banks of eight nibbles, also seen at memory 00h-1fh
// - flag at zero forces bank zero
// - active bank is flag AND field; field top bits read zero
// - call saves the flag, return restores it
// - interrupt saves flag, loads vector value; return restores
// - field is not auto-saved; pushed with memory bank as a byte
// - flag by bit set/clear, field by bank-choose or by the banks pop
// - nibble use: accumulator plus seven other registers
// - pair use: four pairs from the active bank
// - primed pairs live in active bank with bit 0 inverted
// - accumulator pair is the 8-bit accumulator
// - pointer pair is main data pointer, aux pair secondary
// - return jumps to the address popped from the stack
module bgrf_core (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // bank flag and field
  input wire logic bit_on_i,
  input wire logic bit_off_i,
  input wire logic sel_wr_i,
  input wire logic [bgrf_pkg::BANK_W-1:0] sel_bank_i,
  // nibble and pair access
  input wire logic [bgrf_pkg::RIDX_W-1:0] nib_rd_idx_i,
  input wire logic nib_we_i,
  input wire logic [bgrf_pkg::RIDX_W-1:0] nib_wr_idx_i,
  input wire logic [bgrf_pkg::NIB_W-1:0] nib_wdata_i,
  input wire logic [bgrf_pkg::PSEL_W-1:0] pair_rd_sel_i,
  input wire logic pair_we_i,
  input wire logic [bgrf_pkg::PSEL_W-1:0] pair_wr_sel_i,
  input wire logic [bgrf_pkg::PAIR_W-1:0] pair_wdata_i,
  // data memory bank 0 access
  input wire logic [bgrf_pkg::MEM_AW-1:0] mem_addr_i,
  input wire logic mem_we_i,
  input wire logic [bgrf_pkg::NIB_W-1:0] mem_wdata_i,
  // stack setup
  input wire logic sp_wr_i,
  input wire logic [bgrf_pkg::SP_W-1:0] sp_wdata_i,
  input wire logic sbs_wr_i,
  input wire logic [bgrf_pkg::SBS_W-1:0] sbs_wdata_i,
  // sequencer requests
  input wire bgrf_pkg::bgrf_op_t op_i,
  input wire logic [bgrf_pkg::PSEL_W-1:0] op_pair_i,
  input wire logic [bgrf_pkg::RET_W-1:0] call_addr_i,
  input wire logic vec_rbe_i,
  input wire logic [bgrf_pkg::NIB_W-1:0] mem_bank_choice_i,
  input wire logic [bgrf_pkg::PAIR_W-1:0] stk_rdata_i,
  // bank state
  output logic bank_choice_on_o,
  output logic [bgrf_pkg::NIB_W-1:0] bank_choice_field_o,
  output logic [bgrf_pkg::BANK_W-1:0] active_bank_num_o,
  output logic [bgrf_pkg::BANK_W-1:0] alt_bank_o,
  // read data
  output logic [bgrf_pkg::NIB_W-1:0] nib_rdata_o,
  output logic [bgrf_pkg::NIB_W-1:0] acc_o,
  output logic [bgrf_pkg::PAIR_W-1:0] pair_rdata_o,
  output logic [bgrf_pkg::PAIR_W-1:0] acc_pair_o,
  output logic [bgrf_pkg::PAIR_W-1:0] ptr_pair_o,
  output logic [bgrf_pkg::PAIR_W-1:0] aux_ptr_pair_o,
  output logic [bgrf_pkg::NIB_W-1:0] mem_rdata_o,
  output logic mem_hit_o,
  // stack side
  output logic [bgrf_pkg::SP_W-1:0] stack_ptr_o,
  output logic [bgrf_pkg::SBS_W-1:0] stack_bank_choice_o,
  output logic stk_we_o,
  output logic stk_re_o,
  output logic [bgrf_pkg::STK_AW-1:0] stk_addr_o,
  output logic [bgrf_pkg::PAIR_W-1:0] stk_wdata_o,
  output logic ret_valid_o,
  output logic [bgrf_pkg::RET_W-1:0] ret_addr_o,
  output logic mbs_load_o,
  output logic [bgrf_pkg::NIB_W-1:0] mbs_data_o,
  output logic busy_o
);
  import bgrf_pkg::*;

  function automatic logic [REG_AW-1:0] pair_addr(
    input logic [BANK_W-1:0] act,
    input logic [PSEL_W-1:0] sel
  );
    logic [BANK_W-1:0] b;
    b = sel[2] ? (act ^ ALT_FLIP) : act;
    return {b, sel[1:0], 1'b0};
  endfunction : pair_addr

  // ==========================================================
  // bank selection
  logic bank_choice_on, next_on;
  logic [NIB_W-1:0] field, next_field;
  logic [BANK_W-1:0] act_bank, alt_bank;
  logic [NIB_W-1:0] regs [REG_CNT];
  logic [NIB_W-1:0] next_regs [REG_CNT];
  bgrf_state_t st, next_st;
  bgrf_op_t op_q, next_op_q;
  logic [PSEL_W-1:0] pair_q, next_pair_q;
  logic second, next_second;
  logic [PAIR_W-1:0] hold_hi, next_hold_hi;
  logic accept, rd_last, sp_dec, sp_inc;

  assign act_bank = field[1:0] & {BANK_W{bank_choice_on}};
  assign alt_bank = act_bank ^ ALT_FLIP;
  assign accept = (st == BGRF_ST_IDLE) && (op_i != BGRF_OP_NOP);
  assign rd_last = (st == BGRF_ST_RD_DATA) &&
    (second || !(op_q == BGRF_OP_RET || op_q == BGRF_OP_INT_RET));
  assign bank_choice_on_o = bank_choice_on;
  assign bank_choice_field_o = field;

  always_comb begin
    next_on = bank_choice_on;
    next_field = field;
    if (rd_last && (op_q == BGRF_OP_RET || op_q == BGRF_OP_INT_RET)) begin
      next_on = hold_hi[FLAG_BIT];
    end else if (accept && op_i == BGRF_OP_INT_ENTER) begin
      next_on = vec_rbe_i;
    end else if (bit_on_i) begin
      next_on = 1'b1;
    end else if (bit_off_i) begin
      next_on = 1'b0;
    end
    if (rd_last && op_q == BGRF_OP_POP_BANKS) begin
      next_field = {2'b00, stk_rdata_i[1:0]};
    end else if (sel_wr_i) begin
      next_field = {2'b00, sel_bank_i};
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bank_choice_on <= RBE_RESET;
      field <= FIELD_RESET;
    end else begin
      bank_choice_on <= next_on;
      field <= next_field;
    end
  end

  // ==========================================================
  // register storage, one write port of two nibbles
  logic wr_lo, wr_hi;
  logic [REG_AW-1:0] wr_a;
  logic [NIB_W-1:0] wr_dl, wr_dh;

  // popped pair beats memory port, which beats the core's own writes
  always_comb begin
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    wr_a = '0;
    wr_dl = '0;
    wr_dh = '0;
    if (rd_last && op_q == BGRF_OP_POP_PAIR) begin
      wr_lo = 1'b1;
      wr_hi = 1'b1;
      wr_a = pair_addr(act_bank, pair_q);
      {wr_dh, wr_dl} = stk_rdata_i;
    end else if (mem_we_i && mem_addr_i <= REG_AREA_TOP) begin
      wr_lo = 1'b1;
      wr_a = mem_addr_i[REG_AW-1:0];
      wr_dl = mem_wdata_i;
    end else if (pair_we_i) begin
      wr_lo = 1'b1;
      wr_hi = 1'b1;
      wr_a = pair_addr(act_bank, pair_wr_sel_i);
      {wr_dh, wr_dl} = pair_wdata_i;
    end else if (nib_we_i) begin
      wr_lo = 1'b1;
      wr_a = {act_bank, nib_wr_idx_i};
      wr_dl = nib_wdata_i;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < REG_CNT; gi++) begin : g_ent
      always_comb begin
        next_regs[gi] = regs[gi];
        if (wr_lo && wr_a == REG_AW'(gi)) begin
          next_regs[gi] = wr_dl;
        end
        if (wr_hi && (wr_a | 5'h01) == REG_AW'(gi)) begin
          next_regs[gi] = wr_dh;
        end
      end
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          regs[gi] <= '0;
        end else begin
          regs[gi] <= next_regs[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // registered read ports
  logic [REG_AW-1:0] pa_rd, pa_acc, pa_ptr, pa_aux;
  assign pa_rd = pair_addr(act_bank, pair_rd_sel_i);
  assign pa_acc = {act_bank, BGRF_PAIR_ACC, 1'b0};
  assign pa_ptr = {act_bank, BGRF_PAIR_PTR, 1'b0};
  assign pa_aux = {act_bank, BGRF_PAIR_AUX, 1'b0};

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active_bank_num_o <= '0;
      alt_bank_o <= '0;
      nib_rdata_o <= '0;
      acc_o <= '0;
      pair_rdata_o <= '0;
      acc_pair_o <= '0;
      ptr_pair_o <= '0;
      aux_ptr_pair_o <= '0;
      mem_rdata_o <= '0;
      mem_hit_o <= 1'b0;
    end else begin
      active_bank_num_o <= act_bank;
      alt_bank_o <= alt_bank;
      nib_rdata_o <= regs[{act_bank, nib_rd_idx_i}];
      acc_o <= regs[pa_acc];
      pair_rdata_o <= {regs[pa_rd | 5'h01], regs[pa_rd]};
      acc_pair_o <= {regs[pa_acc | 5'h01], regs[pa_acc]};
      ptr_pair_o <= {regs[pa_ptr | 5'h01], regs[pa_ptr]};
      aux_ptr_pair_o <= {regs[pa_aux | 5'h01], regs[pa_aux]};
      mem_rdata_o <= (mem_addr_i <= REG_AREA_TOP) ?
        regs[mem_addr_i[REG_AW-1:0]] : '0;
      mem_hit_o <= (mem_addr_i <= REG_AREA_TOP);
    end
  end

  // ==========================================================
  // stack sequencer
  bgrf_stack_addr u_stack (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .sp_wr_i(sp_wr_i),
    .sp_wdata_i(sp_wdata_i),
    .sbs_wr_i(sbs_wr_i),
    .sbs_wdata_i(sbs_wdata_i),
    .dec_i(sp_dec),
    .inc_i(sp_inc),
    .sp_o(stack_ptr_o),
    .sbs_o(stack_bank_choice_o)
  );

  logic next_we, next_re, next_ret_v, next_mbs_ld;
  logic [STK_AW-1:0] next_addr;
  logic [PAIR_W-1:0] next_wdata;
  logic [RET_W-1:0] next_ret_a;
  logic [NIB_W-1:0] next_mbs_d;
  logic [SP_W-1:0] push_at;

  assign push_at = stack_ptr_o - SP_STEP;

  always_comb begin
    next_st = st;
    next_op_q = op_q;
    next_pair_q = pair_q;
    next_second = second;
    next_hold_hi = hold_hi;
    next_we = 1'b0;
    next_re = 1'b0;
    next_addr = stk_addr_o;
    next_wdata = stk_wdata_o;
    next_ret_v = 1'b0;
    next_ret_a = ret_addr_o;
    next_mbs_ld = 1'b0;
    next_mbs_d = mbs_data_o;
    sp_dec = 1'b0;
    sp_inc = 1'b0;
    case (st)
      BGRF_ST_IDLE: begin
        if (accept) begin
          next_op_q = op_i;
          next_pair_q = op_pair_i;
          next_second = 1'b0;
          // the flag rides in the high word, above the address
          next_hold_hi = {bank_choice_on, 3'b000, call_addr_i[11:8]};
          case (op_i)
            BGRF_OP_PUSH_PAIR, BGRF_OP_PUSH_BANKS,
            BGRF_OP_CALL, BGRF_OP_INT_ENTER: begin
              next_we = 1'b1;
              sp_dec = 1'b1;
              next_addr = {stack_bank_choice_o, push_at};
              if (op_i == BGRF_OP_PUSH_PAIR) begin
                next_wdata = {regs[pair_addr(act_bank, op_pair_i) | 5'h01],
                  regs[pair_addr(act_bank, op_pair_i)]};
              end else if (op_i == BGRF_OP_PUSH_BANKS) begin
                next_wdata = {mem_bank_choice_i, field};
              end else begin
                next_wdata = call_addr_i[7:0];
                next_st = BGRF_ST_CALL_HI;
              end
            end
            default: begin
              next_re = 1'b1;
              sp_inc = 1'b1;
              next_addr = {stack_bank_choice_o, stack_ptr_o};
              next_st = BGRF_ST_RD_WAIT;
            end
          endcase
        end
      end
      BGRF_ST_CALL_HI: begin
        next_we = 1'b1;
        sp_dec = 1'b1;
        next_addr = {stack_bank_choice_o, push_at};
        next_wdata = hold_hi;
        next_st = BGRF_ST_IDLE;
      end
      BGRF_ST_RD_WAIT: begin
        next_st = BGRF_ST_RD_DATA;
      end
      BGRF_ST_RD_DATA: begin
        if (rd_last) begin
          next_st = BGRF_ST_IDLE;
          if (op_q == BGRF_OP_RET || op_q == BGRF_OP_INT_RET) begin
            next_ret_v = 1'b1;
            next_ret_a = {hold_hi[3:0], stk_rdata_i};
          end
          if (op_q == BGRF_OP_POP_BANKS) begin
            next_mbs_ld = 1'b1;
            next_mbs_d = stk_rdata_i[7:4];
          end
        end else begin
          next_hold_hi = stk_rdata_i;
          next_second = 1'b1;
          next_re = 1'b1;
          sp_inc = 1'b1;
          next_addr = {stack_bank_choice_o, stack_ptr_o};
          next_st = BGRF_ST_RD_WAIT;
        end
      end
      default: begin
        next_st = BGRF_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= BGRF_ST_IDLE;
      op_q <= BGRF_OP_NOP;
      pair_q <= '0;
      second <= 1'b0;
      hold_hi <= '0;
      stk_we_o <= 1'b0;
      stk_re_o <= 1'b0;
      stk_addr_o <= '0;
      stk_wdata_o <= '0;
      ret_valid_o <= 1'b0;
      ret_addr_o <= '0;
      mbs_load_o <= 1'b0;
      mbs_data_o <= '0;
      busy_o <= 1'b0;
    end else begin
      st <= next_st;
      op_q <= next_op_q;
      pair_q <= next_pair_q;
      second <= next_second;
      hold_hi <= next_hold_hi;
      stk_we_o <= next_we;
      stk_re_o <= next_re;
      stk_addr_o <= next_addr;
      stk_wdata_o <= next_wdata;
      ret_valid_o <= next_ret_v;
      ret_addr_o <= next_ret_a;
      mbs_load_o <= next_mbs_ld;
      mbs_data_o <= next_mbs_d;
      busy_o <= (next_st != BGRF_ST_IDLE);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  chk_flag_off_bank: assert property (!bank_choice_on |=>
    active_bank_num_o == 2'h0) else $error("flag off but bank not zero");
  chk_field_top_zero: assert property (bank_choice_on |=>
    bank_choice_field_o[3:2] == 2'b00 && active_bank_num_o ==
    $past(bank_choice_field_o[1:0])) else $error("bad active bank");
  chk_push_sp_step: assert property (accept &&
    op_i == BGRF_OP_PUSH_PAIR |=> stk_we_o &&
    stack_ptr_o == $past(stack_ptr_o) - 8'h02 &&
    stk_addr_o == {$past(stack_bank_choice_o), stack_ptr_o})
    else $error("push did not predecrement");
  chk_pop_addr: assert property (accept && op_i == BGRF_OP_POP_PAIR
    |=> stk_re_o && stk_addr_o == {$past(stack_bank_choice_o),
    $past(stack_ptr_o)} ##2 !busy_o)
    else $error("pop address or length wrong");
  chk_call_flag_saved: assert property (accept &&
    op_i == BGRF_OP_CALL |-> ##2 stk_we_o &&
    stk_wdata_o[7] == $past(bank_choice_on, 2))
    else $error("call lost the flag");
  chk_int_flag_load: assert property (accept &&
    op_i == BGRF_OP_INT_ENTER |=> bank_choice_on == $past(vec_rbe_i))
    else $error("vector flag not loaded");
  chk_ret_timing: assert property (accept && op_i == BGRF_OP_RET
    |-> ##5 ret_valid_o && bank_choice_on == $past(stk_rdata_i[7], 3))
    else $error("return late or flag wrong");
  chk_sel_write: assert property (sel_wr_i && st == BGRF_ST_IDLE
    |=> field == {2'b00, $past(sel_bank_i)})
    else $error("bank choose not applied");
  chk_alt_pair_read: assert property (pair_rd_sel_i[2]
    |=> pair_rdata_o[3:0] ==
    $past(regs[{alt_bank, pair_rd_sel_i[1:0], 1'b0}]))
    else $error("primed pair from wrong bank");

  cov_push_pop: cover property (accept && op_i == BGRF_OP_PUSH_PAIR
    ##[1:8] accept && op_i == BGRF_OP_POP_PAIR);
  cov_int_return: cover property (accept && op_i == BGRF_OP_INT_ENTER
    ##[2:20] ret_valid_o);
  cov_banks_pop: cover property (mbs_load_o);
endmodule : bgrf_core

`default_nettype wire

// ===== tb/bgrf_stack_mem.sv
/*
  Stack memory model on the far side of the register file.
  Assumes one access per cycle; read data is due the cycle after.
*/
`default_nettype none

module bgrf_stack_mem (
  // clock
  input wire logic clock_i,
  // access
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [9:0] addr_i,
  input wire logic [7:0] wdata_i,
  // answer
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [1024];
  initial rdata_o = 8'h00;
  always @(posedge clock_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
    // off the answer cycle the bus toggles, so stale data cannot pass
    if (re_i) rdata_o <= mem[addr_i];
    else rdata_o <= ~rdata_o;
  end
endmodule : bgrf_stack_mem

`default_nettype wire

// ===== tb/tb.sv
/*
  Self-checking bench for bgrf_core with a register content model.
  Assumes the stack memory model answers the cycle after a read.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bgrf_pkg::*;
  // ==========================================================
  // stimulus and outputs
  logic clock_i = 0, rstn_i = 0, bit_on_i = 0, bit_off_i = 0;
  logic sel_wr_i = 0, nib_we_i = 0, pair_we_i = 0, mem_we_i = 0;
  logic sp_wr_i = 0, sbs_wr_i = 0, vec_rbe_i = 0;
  logic [1:0] sel_bank_i = 0, sbs_wdata_i = 0;
  logic [2:0] nib_rd_idx_i = 0, nib_wr_idx_i = 0, op_pair_i = 0;
  logic [2:0] pair_rd_sel_i = 0, pair_wr_sel_i = 0;
  logic [3:0] nib_wdata_i = 0, mem_wdata_i = 0, mem_bank_choice_i = 0;
  logic [7:0] pair_wdata_i = 0, mem_addr_i = 0, sp_wdata_i = 0;
  logic [11:0] call_addr_i = 0;
  bgrf_op_t op_i = BGRF_OP_NOP;
  wire logic [7:0] stk_rdata_i;
  logic bank_choice_on_o, mem_hit_o, stk_we_o, stk_re_o, ret_valid_o;
  logic mbs_load_o, busy_o;
  logic [1:0] active_bank_num_o, alt_bank_o, stack_bank_choice_o;
  logic [3:0] bank_choice_field_o, nib_rdata_o, acc_o, mem_rdata_o;
  logic [3:0] mbs_data_o, mb;
  logic [7:0] pair_rdata_o, acc_pair_o, ptr_pair_o, aux_ptr_pair_o;
  logic [7:0] stack_ptr_o, stk_wdata_o, wd, v;
  logic [9:0] stk_addr_o, wa;
  logic [11:0] ret_addr_o, ra;
  // model state
  logic [3:0] rf [32];
  logic flag = 0;
  logic [1:0] fld = 0;
  logic [31:0] seed = 32'h7886, r;
  int err_count = 0, n_tests = 0, i;

  bgrf_core dut (.clock_i, .rstn_i, .bit_on_i, .bit_off_i, .sel_wr_i,
    .sel_bank_i, .nib_rd_idx_i, .nib_we_i, .nib_wr_idx_i, .nib_wdata_i,
    .pair_rd_sel_i, .pair_we_i, .pair_wr_sel_i, .pair_wdata_i,
    .mem_addr_i, .mem_we_i, .mem_wdata_i, .sp_wr_i, .sp_wdata_i,
    .sbs_wr_i, .sbs_wdata_i, .op_i, .op_pair_i, .call_addr_i, .vec_rbe_i,
    .mem_bank_choice_i, .stk_rdata_i, .bank_choice_on_o,
    .bank_choice_field_o, .active_bank_num_o, .alt_bank_o, .nib_rdata_o,
    .acc_o, .pair_rdata_o, .acc_pair_o, .ptr_pair_o, .aux_ptr_pair_o,
    .mem_rdata_o, .mem_hit_o, .stack_ptr_o, .stack_bank_choice_o,
    .stk_we_o, .stk_re_o, .stk_addr_o, .stk_wdata_o, .ret_valid_o,
    .ret_addr_o, .mbs_load_o, .mbs_data_o, .busy_o);
  bgrf_stack_mem stack_mem (.clock_i, .we_i(stk_we_o), .re_i(stk_re_o),
    .addr_i(stk_addr_o), .wdata_i(stk_wdata_o), .rdata_o(stk_rdata_i));

  always #20 clock_i = ~clock_i;
  // pulses are latched so checks need not hit their single cycle
  always @(posedge clock_i) begin
    if (stk_we_o) {wa, wd} <= {stk_addr_o, stk_wdata_o};
    if (ret_valid_o) ra <= ret_addr_o;
    if (mbs_load_o) mb <= mbs_data_o;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [1:0] bk();
    return flag ? fld : 2'h0;
  endfunction : bk
  function automatic logic [4:0] pidx(input logic [2:0] s);
    return {bk() ^ {1'b0, s[2]}, s[1:0], 1'b0};
  endfunction : pidx
  function automatic logic [7:0] pv(input logic [2:0] s);
    return {rf[pidx(s) | 5'h01], rf[pidx(s)]};
  endfunction : pv
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic setb(input logic f, input logic [1:0] b);
    {bit_on_i, bit_off_i, sel_wr_i, sel_bank_i} = {f, !f, 1'b1, b};
    @(negedge clock_i);
    {bit_on_i, bit_off_i, sel_wr_i} = 3'h0;
    {flag, fld} = {f, b};
    @(negedge clock_i);
  endtask : setb
  task automatic chk_regs();
    for (int p = 0; p < 8; p++) begin
      pair_rd_sel_i = p[2:0];
      nib_rd_idx_i = p[2:0];
      @(negedge clock_i);
      chk(pair_rdata_o, pv(p[2:0]));
      chk(nib_rdata_o, rf[{bk(), p[2:0]}]);
    end
    chk(active_bank_num_o, bk());
    chk(alt_bank_o, bk() ^ 2'h1);
    chk(bank_choice_field_o, {2'h0, fld});
    chk(bank_choice_on_o, flag);
    chk(acc_o, rf[{bk(), 3'h0}]);
    chk(acc_pair_o, pv(3'h0));
    chk(ptr_pair_o, pv(3'h1));
    chk(aux_ptr_pair_o, pv(3'h2));
  endtask : chk_regs
  task automatic run_op(input bgrf_op_t op, input logic [2:0] p);
    int n;
    {op_i, op_pair_i} = {op, p};
    @(negedge clock_i);
    op_i = BGRF_OP_NOP;
    for (n = 0; n < 20 && busy_o !== 1'b0; n++) @(negedge clock_i);
    if (n == 20) begin
      err_count++;
      end_sim();
    end
    repeat (2) @(negedge clock_i);
  endtask : run_op
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(negedge clock_i);
    rstn_i = 1;
    chk({bank_choice_on_o, bank_choice_field_o}, 12'h0);
    chk({stack_bank_choice_o, stack_ptr_o}, 12'h0);
    $display("test reset done");
    for (i = 0; i < 32; i++) begin
      r = rnd();
      {mem_addr_i, mem_wdata_i, mem_we_i} = {i[7:0], r[3:0], 1'b1};
      rf[i] = r[3:0];
      @(negedge clock_i);
    end
    mem_we_i = 0;
    for (i = 0; i < 8; i++) begin
      setb(i[2], i[1:0]);
      chk_regs();
      r = rnd();
      {nib_we_i, nib_wr_idx_i, nib_wdata_i} = {1'b1, r[2:0], r[7:4]};
      rf[{bk(), r[2:0]}] = r[7:4];
      @(negedge clock_i);
      nib_we_i = 0;
      {pair_we_i, pair_wr_sel_i, pair_wdata_i} = {1'b1, r[10:8], r[23:16]};
      {rf[pidx(r[10:8]) | 5'h01], rf[pidx(r[10:8])]} = r[23:16];
      @(negedge clock_i);
      pair_we_i = 0;
    end
    for (i = 0; i < 33; i++) begin
      mem_addr_i = i[7:0];
      @(negedge clock_i);
      chk(mem_hit_o, i < 32);
      chk(mem_rdata_o, i < 32 ? rf[i[4:0]] : 4'h0);
    end
    $display("test banks done");
    setb(1'b1, 2'h2);
    {sp_wr_i, sp_wdata_i, sbs_wr_i, sbs_wdata_i} = {1'b1, 8'h40, 1'b1, 2'h2};
    @(negedge clock_i);
    {sp_wr_i, sbs_wr_i} = 2'h0;
    v = pv(3'h1);
    run_op(BGRF_OP_PUSH_PAIR, 3'h1);
    chk(wa, {2'h2, 8'h3e});
    chk(wd, v);
    chk(stack_ptr_o, 8'h3e);
    run_op(BGRF_OP_POP_PAIR, 3'h2);
    {rf[pidx(3'h2) | 5'h01], rf[pidx(3'h2)]} = v;
    chk(stack_ptr_o, 8'h40);
    chk_regs();
    r = rnd();
    mem_bank_choice_i = r[3:0];
    run_op(BGRF_OP_PUSH_BANKS, 3'h0);
    chk(wd, {r[3:0], 4'h2});
    setb(1'b1, 2'h1);
    run_op(BGRF_OP_POP_BANKS, 3'h0);
    fld = 2'h2;
    chk(bank_choice_field_o, 4'h2);
    chk(mb, r[3:0]);
    $display("test push pop done");
    call_addr_i = r[27:16];
    run_op(BGRF_OP_CALL, 3'h0);
    chk(wd, {4'h8, r[27:24]});
    setb(1'b0, 2'h2);
    run_op(BGRF_OP_RET, 3'h0);
    flag = 1;
    chk(ra, r[27:16]);
    chk(bank_choice_on_o, 1'b1);
    for (i = 0; i < 2; i++) begin
      setb(i[0], 2'h2);
      vec_rbe_i = !i[0];
      // fresh address, so a missing return pulse cannot pass
      r = rnd();
      call_addr_i = r[11:0];
      run_op(BGRF_OP_INT_ENTER, 3'h0);
      chk(bank_choice_on_o, !i[0]);
      chk(wd, {i[0], 3'h0, r[11:8]});
      run_op(BGRF_OP_INT_RET, 3'h0);
      chk(bank_choice_on_o, i[0]);
      chk(ra, r[11:0]);
    end
    $display("test call done");
    v = pv(3'h0);
    run_op(BGRF_OP_PUSH_PAIR, 3'h3);
    run_op(BGRF_OP_PUSH_PAIR, 3'h0);
    run_op(BGRF_OP_RET, 3'h0);
    chk(ra, {v[3:0], pv(3'h3)});
    chk(bank_choice_on_o, v[7]);
    chk(stack_ptr_o, 8'h40);
    $display("test jump done");
    end_sim();
  end
endmodule : tb

`default_nettype wire
